// >>> design/pdad_detector.sv
// Design decisions made here: the register addresses and the Wishbone register port.
`timescale 1ns/1ps
module pdad_detector #(
	parameter logic [6:0] DSD_BITS_PER_FS = 7'h40
) (
	// clock, reset, enable
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	input  wire logic        ce_i,
	// wishbone slave
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [7:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic      [31:0] wb_dat_o,
	output logic             wb_ack_o,
	// audio pins
	input  wire logic        power_down_n_pin_i,
	input  wire logic        serial_bit_clock_i,
	input  wire logic        frame_clock_i,
	input  wire logic        serial_data1_in_i,
	input  wire logic        serial_data2_in_i,
	input  wire logic        mclk_running_i,
	// datapath side
	input  wire logic        att_output_zero_i,
	output logic             dsd_mode_o,
	output logic             internal_reset_o,
	output logic             analog_hiz_o,
	output logic             standby_o,
	output logic             fullscale_mute_o,
	output logic [8:0]       latency_extra_o
);
	import pdad_pkg::*;

	// whole block state
	typedef struct packed {
		logic [2:0]   bck_sync;   // [0] first stage only
		logic [1:0]   frm_sync;
		logic [1:0]   d1_sync;
		logic [1:0]   d2_sync;
		logic [1:0]   pdn_sync;
		logic [1:0]   mck_sync;
		logic [11:0]  ctrl;       // software control word
		logic [31:0]  frm_shift;  // frame pin history
		logic [15:0]  d1_shift;
		logic [15:0]  d2_shift;
		logic [4:0]   frm_run;    // repeats of same level
		logic [7:0]   frm_period; // bits since last rise
		logic [5:0]   obs_cnt;
		pdad_det_type det;
		logic         pend_dsd;
		logic         mode_dsd;   // detected mode
		logic [6:0]   dsd_tick;
		logic [13:0]  zero_cnt;
		logic [13:0]  outz_cnt;
		logic [8:0]   fsc_cnt;
		logic         irst;
		logic [2:0]   irst_cnt;
		logic         eff_dsd;
		logic [8:0]   lat;
		logic         fs_mute;
		logic         ack;
		logic [31:0]  rdat;
	} pdad_state_type;

	pdad_state_type st_reg;   // registered state
	pdad_state_type st_next;  // next state

	// decoded helpers
	logic        bit_edge;    // rising edge of bit clock
	logic        frm_bit;
	logic        d1_bit;
	logic        d2_bit;
	logic [31:0] frm_sh_n;
	logic        frm_rise;
	logic        dsd_hit;
	logic        pcm_hit;
	logic        fs_tick;     // one sample period
	logic        zero_hit;
	logic        outz_hit;
	logic        fsc_hit;
	logic        run;         // detection allowed
	logic        auto_en;
	logic        bus_req;
	logic [13:0] zw_limit;
	logic [8:0]  fsc_limit;

	// edge found from synchronised stages two and three only
	assign bit_edge = st_reg.bck_sync[1] & ~st_reg.bck_sync[2];
	assign frm_bit  = st_reg.frm_sync[1];
	assign d1_bit   = st_reg.d1_sync[1];
	assign d2_bit   = st_reg.d2_sync[1];
	assign frm_sh_n = {st_reg.frm_shift[30:0], frm_bit};
	assign frm_rise = frm_bit & ~st_reg.frm_shift[0];
	// a zero code seen twice back to back
	assign dsd_hit  = (frm_sh_n[31:16] == frm_sh_n[15:0])
		& pdad_is_zpat(frm_sh_n[15:0]);
	// period a multiple of 16 bits, or 32 equal samples
	assign pcm_hit  = (frm_rise & (st_reg.frm_period[3:0] == 4'hF)
		& (st_reg.frm_period != 8'hFF))
		| ((frm_bit == st_reg.frm_shift[0])
		& (st_reg.frm_run >= CONST_RUN - 5'h01));
	assign fs_tick  = bit_edge & (st_reg.mode_dsd
		? (st_reg.dsd_tick == DSD_BITS_PER_FS - 7'h01) : frm_rise);
	assign auto_en  = st_reg.ctrl[C_AUTO_EN];
	assign zw_limit = pdad_zero_wait(st_reg.ctrl[C_ZW_LSB+1:C_ZW_LSB]);
	assign fsc_limit = st_reg.ctrl[C_FS_TIME] ? FS_DET_SHORT : FS_DET_LONG;
	assign zero_hit = st_reg.zero_cnt >= zw_limit;
	assign outz_hit = st_reg.outz_cnt >= zw_limit;
	assign fsc_hit  = st_reg.fsc_cnt >= fsc_limit;
	// start conditions; the external filter bit plays no part
	assign run = auto_en & st_reg.ctrl[C_ROUTE] & st_reg.pdn_sync[1]
		& (zero_hit | outz_hit | (st_reg.mode_dsd & fsc_hit)
		| ~(st_reg.ctrl[C_PW1] | st_reg.ctrl[C_PW2])
		| ~st_reg.ctrl[C_SRST_N]);
	assign bus_req = wb_cyc_i & wb_stb_i & ~st_reg.ack;

	// outputs straight from state flops
	assign wb_dat_o         = st_reg.rdat;
	assign wb_ack_o         = st_reg.ack;
	assign dsd_mode_o       = st_reg.eff_dsd;
	assign internal_reset_o = st_reg.irst;
	assign analog_hiz_o     = ~st_reg.mck_sync[1];
	assign standby_o        = ~st_reg.mck_sync[1];
	assign fullscale_mute_o = st_reg.fs_mute;
	assign latency_extra_o  = st_reg.lat;

	// next-state logic for the whole block
	always_comb begin
		st_next = st_reg;
		// two-stage synchronisers for every pin but the bit clock, which has three
		st_next.bck_sync = {st_reg.bck_sync[1:0], serial_bit_clock_i};
		st_next.frm_sync = {st_reg.frm_sync[0], frame_clock_i};
		st_next.d1_sync  = {st_reg.d1_sync[0], serial_data1_in_i};
		st_next.d2_sync  = {st_reg.d2_sync[0], serial_data2_in_i};
		st_next.pdn_sync = {st_reg.pdn_sync[0], power_down_n_pin_i};
		st_next.mck_sync = {st_reg.mck_sync[0], mclk_running_i};

		// bus: one wait state, ack drops the cycle after
		st_next.ack = bus_req;
		// a write lands on the edge that samples ack high, never on the
		// request edge, so the control word only moves on a finished cycle
		if (wb_cyc_i && wb_stb_i && wb_we_i && st_reg.ack
			&& wb_adr_i == CTRL_ADDR) begin
			if (wb_sel_i[0]) begin
				st_next.ctrl[7:0] = wb_dat_i[7:0];
			end
			if (wb_sel_i[1]) begin
				st_next.ctrl[11:8] = wb_dat_i[11:8];
			end
		end
		// read data is captured at the request edge and stands with ack
		if (bus_req) begin
			case (wb_adr_i)
				CTRL_ADDR:   st_next.rdat = {20'h00000, st_reg.ctrl};
				STATUS_ADDR: st_next.rdat = {27'h0000000,
					~st_reg.mck_sync[1], st_reg.irst, run,
					st_reg.eff_dsd,
					auto_en & st_reg.mode_dsd};
				default:     st_next.rdat = 32'h00000000;
			endcase
		end

		// everything in this branch moves only on bit clock edges;
		// a stopped bit clock freezes the mode as it is
		if (bit_edge) begin
			st_next.frm_shift = frm_sh_n;
			st_next.d1_shift  = {st_reg.d1_shift[14:0], d1_bit};
			st_next.d2_shift  = {st_reg.d2_shift[14:0], d2_bit};
			// level run length, saturating
			if (frm_bit != st_reg.frm_shift[0]) begin
				st_next.frm_run = 5'h00;
			end else if (st_reg.frm_run != CONST_RUN) begin
				st_next.frm_run = st_reg.frm_run + 5'h01;
			end
			// rise-to-rise spacing, saturating
			if (frm_rise) begin
				st_next.frm_period = 8'h00;
			end else if (st_reg.frm_period != 8'hFF) begin
				st_next.frm_period = st_reg.frm_period + 8'h01;
			end
			// sample period divider in one-bit mode
			if (fs_tick || !st_reg.mode_dsd) begin
				st_next.dsd_tick = 7'h00;
			end else begin
				st_next.dsd_tick = st_reg.dsd_tick + 7'h01;
			end
			// input zero: any one in PCM restarts at once
			if (!st_reg.mode_dsd && (d1_bit || d2_bit)) begin
				st_next.zero_cnt = 14'h0000;
			end else if (fs_tick) begin
				if (st_reg.mode_dsd && !(pdad_is_zpat(st_reg.d1_shift)
					&& pdad_is_zpat(st_reg.d2_shift)
					&& pdad_is_zpat(st_reg.frm_shift[15:0]))) begin
					st_next.zero_cnt = 14'h0000;
				end else if (!zero_hit) begin
					st_next.zero_cnt = st_reg.zero_cnt + 14'h0001;
				end
			end
			// output zero held by attenuator or mute
			if (!att_output_zero_i) begin
				st_next.outz_cnt = 14'h0000;
			end else if (fs_tick && !outz_hit) begin
				st_next.outz_cnt = st_reg.outz_cnt + 14'h0001;
			end
			// full-scale: every one-bit line stuck high
			if (!(st_reg.mode_dsd && frm_bit && d1_bit && d2_bit)) begin
				st_next.fsc_cnt = 9'h000;
			end else if (!fsc_hit) begin
				st_next.fsc_cnt = st_reg.fsc_cnt + 9'h001;
			end

			// classifier
			if (!run || st_reg.ctrl[C_EXT_FILT]) begin
				st_next.det = DET_IDLE;
			end else begin
				case (st_reg.det)
					DET_IDLE: begin
						st_next.obs_cnt = 6'h01;
						st_next.det     = DET_OBSERVE;
					end
					DET_OBSERVE: begin
						if (st_reg.obs_cnt != OBSERVE_BITS) begin
							st_next.obs_cnt = st_reg.obs_cnt + 6'h01;
						end else if (dsd_hit) begin
							st_next.pend_dsd = 1'b1;
							st_next.det      = DET_PENDING;
						end else if (pcm_hit) begin
							st_next.pend_dsd = 1'b0;
							st_next.det      = DET_PENDING;
						end
						// neither pattern: keep observing, mode unchanged
					end
					DET_PENDING: begin
						// a constant pin never rises, so PCM by
						// constant level is taken without waiting
						if (frm_rise || (!st_reg.pend_dsd
							&& st_reg.frm_run == CONST_RUN)) begin
							st_next.mode_dsd = st_reg.pend_dsd;
							st_next.obs_cnt  = 6'h01;
							st_next.det      = DET_OBSERVE;
						end
					end
					default: begin
						st_next.det = DET_IDLE;
					end
				endcase
			end
		end

		// power-down pin low returns the mode to PCM
		if (!st_reg.pdn_sync[1]) begin
			st_next.mode_dsd = 1'b0;
			st_next.det      = DET_IDLE;
		end

		// internal reset: released on the fourth sample tick
		if (st_next.mode_dsd != st_reg.mode_dsd) begin
			st_next.irst     = 1'b1;
			st_next.irst_cnt = 3'h0;
		end else if (st_reg.irst && fs_tick) begin
			if (st_reg.irst_cnt == IRST_FS - 3'h1) begin
				st_next.irst = 1'b0;
			end else begin
				st_next.irst_cnt = st_reg.irst_cnt + 3'h1;
			end
		end

		// manual select only counts while auto is off
		st_next.eff_dsd = auto_en ? st_reg.mode_dsd
			: st_reg.ctrl[C_MANUAL];
		// extra output delay from the auto-mode guard
		if (!auto_en) begin
			st_next.lat = 9'h000;
		end else if (st_reg.mode_dsd) begin
			st_next.lat = st_reg.ctrl[C_FS_TIME] ? REG_DLY_SHRT
				: REG_DLY_LONG;
		end else begin
			st_next.lat = PCM_LAT_FS;
		end
		// stuck-high one-bit input is muted, not played
		st_next.fs_mute = st_reg.mode_dsd & fsc_hit
			& st_reg.ctrl[C_FS_MUTE];
	end

	// state register; clock enable freezes everything
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			st_reg <= '0;
		end else if (ce_i) begin
			st_reg <= st_next;
		end
	end

	// checks
	sequence s_bus_req;
		wb_cyc_i && wb_stb_i && !wb_ack_o && ce_i;
	endsequence
	sequence s_bus_ack;
		wb_ack_o ##1 !wb_ack_o;
	endsequence
	sequence s_mode_flip;
		ce_i && st_next.mode_dsd != st_reg.mode_dsd;
	endsequence

	// one classification step: observation done, detection allowed
	sequence s_code_match;
		ce_i && bit_edge && run && !st_reg.ctrl[C_EXT_FILT]
		&& st_reg.det == DET_OBSERVE && st_reg.obs_cnt == OBSERVE_BITS;
	endsequence

	// ack is already high in the cycle after the request edge
	a_bus_answer: assert property (@(posedge clk_i) disable iff (rst_i)
		s_bus_req ##1 ce_i |-> s_bus_ack)
		else $error("bus answer not one cycle long");
	a_result_off: assert property (@(posedge clk_i) disable iff (rst_i)
		ce_i && bus_req && !auto_en && wb_adr_i == STATUS_ADDR
		|=> !wb_dat_o[0])
		else $error("result bit set while auto off");
	a_pdn_clears: assert property (@(posedge clk_i) disable iff (rst_i)
		ce_i && !st_reg.pdn_sync[1] |=> !st_reg.mode_dsd)
		else $error("mode kept while power-down low");
	a_hold_idle: assert property (@(posedge clk_i) disable iff (rst_i)
		ce_i && st_reg.pdn_sync[1] && !run |=> $stable(st_reg.mode_dsd))
		else $error("mode changed without detection");
	a_rise_only: assert property (@(posedge clk_i) disable iff (rst_i)
		ce_i && st_reg.pdn_sync[1] && !(bit_edge && st_reg.det == DET_PENDING)
		|=> $stable(st_reg.mode_dsd))
		else $error("mode changed outside pending update");
	a_irst_start: assert property (@(posedge clk_i) disable iff (rst_i)
		s_mode_flip |=> internal_reset_o && st_reg.irst_cnt == 3'h0)
		else $error("no internal reset on mode change");
	a_irst_release: assert property (@(posedge clk_i) disable iff (rst_i)
		!$past(rst_i) && $fell(st_reg.irst)
		|-> $past(st_reg.irst_cnt) == 3'h3 && $past(fs_tick))
		else $error("internal reset released early");
	a_pcm_latency: assert property (@(posedge clk_i) disable iff (rst_i)
		ce_i && auto_en && !st_reg.mode_dsd |=> latency_extra_o == 9'h012)
		else $error("pcm latency not 18");
	a_dsd_latency: assert property (@(posedge clk_i) disable iff (rst_i)
		ce_i && auto_en && st_reg.mode_dsd && st_reg.ctrl[C_FS_TIME]
		|=> latency_extra_o == 9'h088)
		else $error("dsd latency wrong");
	a_manual_gate: assert property (@(posedge clk_i) disable iff (rst_i)
		ce_i && auto_en |=> dsd_mode_o == $past(st_reg.mode_dsd))
		else $error("manual select leaked through");
	a_power_start: assert property (@(posedge clk_i) disable iff (rst_i)
		auto_en && st_reg.ctrl[C_ROUTE] && st_reg.pdn_sync[1]
		&& !st_reg.ctrl[C_SRST_N] |-> run)
		else $error("reset bit did not start detection");
	a_no_mclk: assert property (@(posedge clk_i) disable iff (rst_i)
		ce_i && !mclk_running_i ##1 ce_i |=> analog_hiz_o && standby_o)
		else $error("outputs not released without master clock");
	a_dsd_pattern: assert property (@(posedge clk_i) disable iff (rst_i)
		s_code_match ##0 dsd_hit |=> st_reg.det == DET_PENDING && st_reg.pend_dsd)
		else $error("doubled zero code not taken as one-bit");
	a_pcm_pattern: assert property (@(posedge clk_i) disable iff (rst_i)
		s_code_match ##0 (!dsd_hit && pcm_hit)
		|=> st_reg.det == DET_PENDING && !st_reg.pend_dsd)
		else $error("frame clock not taken as pcm");
	// no verdict may come before the full observation span
	a_early_eval: assert property (@(posedge clk_i) disable iff (rst_i)
		ce_i && bit_edge && run && !st_reg.ctrl[C_EXT_FILT]
		&& st_reg.det == DET_OBSERVE && st_reg.obs_cnt != OBSERVE_BITS
		|=> st_reg.det == DET_OBSERVE)
		else $error("verdict before observation span");
	a_zero_clear: assert property (@(posedge clk_i) disable iff (rst_i)
		ce_i && bit_edge && !st_reg.mode_dsd && (d1_bit || d2_bit)
		|=> st_reg.zero_cnt == 14'h0000)
		else $error("nonzero data did not restart zero wait");
	a_zero_start: assert property (@(posedge clk_i) disable iff (rst_i)
		auto_en && st_reg.ctrl[C_ROUTE] && st_reg.pdn_sync[1] && zero_hit |-> run)
		else $error("zero wait did not start detection");
	// without bit clock edges the mode may only move by power-down
	a_clock_stall: assert property (@(posedge clk_i) disable iff (rst_i)
		ce_i && !bit_edge && st_reg.pdn_sync[1] |=> $stable(st_reg.mode_dsd))
		else $error("mode moved without bit clock");
	a_mute_set: assert property (@(posedge clk_i) disable iff (rst_i)
		ce_i && st_reg.mode_dsd && fsc_hit && st_reg.ctrl[C_FS_MUTE]
		|=> fullscale_mute_o)
		else $error("full-scale input not muted");
endmodule : pdad_detector

// >>> design/pdad_pkg.sv
// Contract
// - detect only when a start condition holds
// - start after all inputs zero for wait
// - start after outputs zero for wait
// - in DSD, start after full-scale input time
// - start when both powers off or reset
// - wait select picks 8192/4096/2048/1024 plus 18
// - start conditions ignore external filter bit
// - doubled zero pattern on frame pin selects DSD
// - N*16 toggling or 32 constant selects PCM
// - no match keeps current mode
// - detection runs without master clock
// - no master clock: outputs hi-z, standby
// - stopped bit clock holds last mode
// - mode change gives 3-4 fs internal reset
// - observe 34 bits, update on frame rise; PCM by constant level is taken without a rise
// - result bit 0 is PCM, 1 DSD
// - nonzero data stops, zero wait restarts
// - PCM latency 18 fs longer when auto
// - DSD latency follows full-scale detect time
// - power-up runs in PCM mode
// - DSD data stopping keeps DSD mode
// - auto enabled ignores manual DSD select
// - result reads zero when auto disabled
package pdad_pkg;
	// register map
	localparam logic [7:0]  CTRL_ADDR   = 8'h00;
	localparam logic [7:0]  STATUS_ADDR = 8'h04;
	localparam logic [11:0] CTRL_RESET  = 12'h000;
	// control field positions
	localparam int C_AUTO_EN  = 0;
	localparam int C_MANUAL   = 1;
	localparam int C_EXT_FILT = 2;
	localparam int C_PW1      = 3;
	localparam int C_PW2      = 4;
	localparam int C_SRST_N   = 5;
	localparam int C_SOFT_MUTE_CTL    = 6;
	localparam int C_FS_TIME  = 7;
	localparam int C_FS_MUTE  = 8;
	localparam int C_ROUTE    = 9;
	localparam int C_ZW_LSB   = 10;
	// detection constants
	localparam logic [5:0]  OBSERVE_BITS = 6'h22;
	localparam logic [4:0]  CONST_RUN    = 5'h1F;
	localparam logic [2:0]  IRST_FS      = 3'h4;
	localparam logic [13:0] ZW_EXTRA     = 14'h0012;
	localparam logic [8:0]  FS_DET_LONG  = 9'h100;
	localparam logic [8:0]  FS_DET_SHORT = 9'h080;
	localparam logic [8:0]  REG_DLY_LONG = 9'h108;
	localparam logic [8:0]  REG_DLY_SHRT = 9'h088;
	localparam logic [8:0]  PCM_LAT_FS   = 9'h012;
	localparam logic [15:0] ZPAT_A       = 16'h6969;
	localparam logic [15:0] ZPAT_B       = 16'h5555;
	localparam logic [15:0] ZPAT_C       = 16'h3333;
	// detector states
	typedef enum logic [1:0] {
		DET_IDLE    = 2'b00,
		DET_OBSERVE = 2'b01,
		DET_PENDING = 2'b10
	} pdad_det_type;
	// zero-wait length in sample periods
	function automatic logic [13:0] pdad_zero_wait(input logic [1:0] sel);
		case (sel)
			2'b00:   pdad_zero_wait = 14'h2000 + ZW_EXTRA;
			2'b01:   pdad_zero_wait = 14'h1000 + ZW_EXTRA;
			2'b10:   pdad_zero_wait = 14'h0800 + ZW_EXTRA;
			default: pdad_zero_wait = 14'h0400 + ZW_EXTRA;
		endcase
	endfunction : pdad_zero_wait
	// one of the three one-bit zero codes
	function automatic logic pdad_is_zpat(input logic [15:0] w);
		pdad_is_zpat = (w == ZPAT_A) | (w == ZPAT_B) | (w == ZPAT_C);
	endfunction : pdad_is_zpat
endpackage : pdad_pkg

// >>> sim/pdad_source.sv
`timescale 1ns/1ps
module pdad_source (
	// control from the bench
	input  wire logic       run_i,
	input  wire logic [1:0] kind_i,
	// audio pins towards the block
	output logic            bclk_o,
	output logic            frame_o,
	output logic            data1_o,
	output logic            data2_o
);
	import pdad_pkg::*;
	int unsigned bit_cnt; // bits sent so far
	// frame pin: 0 frame clock, 1 zero code, 2 toggle matching nothing, 3 stuck high
	function automatic logic frame_bit(input logic [1:0] k, input int unsigned n);
		case (k)
			2'h1:    frame_bit = ZPAT_A[15 - (n % 16)];
			2'h2:    frame_bit = (n % 24) < 12;
			2'h3:    frame_bit = 1'h1;
			default: frame_bit = (n % 32) < 16;
		endcase
	endfunction : frame_bit
	// lines change on the falling edge so they are settled around the rise
	initial begin
		bclk_o = 1'h0;
		frame_o = 1'h0;
		data1_o = 1'h0;
		data2_o = 1'h0;
		bit_cnt = 0;
		#37;
		forever begin
			if (run_i) begin
				#200 bclk_o = 1'h1;
				#200 bclk_o = 1'h0;
				bit_cnt++;
				frame_o = frame_bit(kind_i, bit_cnt);
				// data pins follow the frame pin for zero code and stuck high, zero samples otherwise
				data1_o = (kind_i == 2'h1 || kind_i == 2'h3) ? frame_o : 1'h0;
				data2_o = data1_o;
			end else begin
				// a stopped bit clock stands low
				#50;
			end
		end
	end
endmodule : pdad_source

// >>> sim/tb.sv
`timescale 1ns/1ps
module tb;
	import pdad_pkg::*;
	// clock, reset and bus
	logic        clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
	logic [7:0]  wb_adr_i;
	logic [3:0]  wb_sel_i;
	logic [31:0] wb_dat_i, wb_dat_o, q;
	// pins and source control
	logic        pdn_n, mclk_on, src_run, bclk, frame, sd1, sd2;
	logic [1:0]  src_kind;
	// datapath side outputs
	logic        dsd_mode_o, irst_o, hiz_o, stby_o, fs_mute_o;
	logic [8:0]  lat_o;
	int          num_errors, checks;

	pdad_detector dut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(1'h1), .wb_cyc_i(wb_cyc_i),
		.wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
		.wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
		.power_down_n_pin_i(pdn_n), .serial_bit_clock_i(bclk), .frame_clock_i(frame),
		.serial_data1_in_i(sd1), .serial_data2_in_i(sd2), .mclk_running_i(mclk_on),
		.att_output_zero_i(1'h0), .dsd_mode_o(dsd_mode_o), .internal_reset_o(irst_o),
		.analog_hiz_o(hiz_o), .standby_o(stby_o), .fullscale_mute_o(fs_mute_o),
		.latency_extra_o(lat_o));
	pdad_source src (.run_i(src_run), .kind_i(src_kind), .bclk_o(bclk), .frame_o(frame),
		.data1_o(sd1), .data2_o(sd2));

	// 50 ns system clock
	initial begin
		clk_i = 1'h0;
		forever #25 clk_i = ~clk_i;
	end
	// print counts and verdict, then end the run
	task automatic stop_test;
		$display("checks=%0d num_errors=%0d", checks, num_errors);
		if (num_errors == 0 && checks > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask : stop_test
	// compare one value, four-state exact
	task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		checks++;
		if (got !== exp) begin
			num_errors++;
			$display("[ERR] %s expected %0h seen %0h", name, exp, got);
		end
	endtask : chk
	// one classic cycle: hold everything until ack is sampled high
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk_i);
		wb_cyc_i <= 1'h1;
		wb_stb_i <= 1'h1;
		wb_we_i <= w;
		wb_sel_i <= 4'h3;
		wb_adr_i <= a;
		wb_dat_i <= d;
		do begin
			@(posedge clk_i);
			n++;
		end while (wb_ack_o !== 1'h1 && n < 50);
		q = wb_dat_o;
		wb_cyc_i <= 1'h0;
		wb_stb_i <= 1'h0;
		wb_we_i <= 1'h0;
		wb_sel_i <= 4'h0;
		if (n >= 50) chk("bus ack", 32'h1, 32'h0);
	endtask : bus
	// bounded wait for the active mode
	task automatic wait_mode(input logic exp, input int lim);
		int n;
		n = 0;
		while (dsd_mode_o !== exp && n < lim) begin
			@(posedge clk_i);
			n++;
		end
		chk("active mode", {31'h0, exp}, {31'h0, dsd_mode_o});
	endtask : wait_mode
	// internal reset length must land between 3 and 4 sample periods
	task automatic irst_len(input int fs);
		int n;
		n = 0;
		while (irst_o === 1'h1 && n < 5 * fs) begin
			@(posedge clk_i);
			n++;
		end
		chk("internal reset length", 32'h1, {31'h0, n >= 3 * fs - 40 && n <= 4 * fs + 40});
	endtask : irst_len
	// reset values, access kinds and an unmapped place
	task automatic t_regs;
		bus(1'h0, CTRL_ADDR, 32'h0);
		chk("ctrl reset", {20'h0, CTRL_RESET}, q);
		bus(1'h0, STATUS_ADDR, 32'h0);
		chk("status at power-up", 32'h0, q);
		bus(1'h1, 8'h10, 32'hFFFFFFFF);
		bus(1'h0, 8'h10, 32'h0);
		chk("unmapped read", 32'h0, q);
		bus(1'h1, CTRL_ADDR, 32'hFFFFFFFF);
		bus(1'h0, CTRL_ADDR, 32'h0);
		chk("ctrl width", 32'h00000FFF, q);
	endtask : t_regs
	// manual select when auto is off, ignored when auto is on
	task automatic t_manual;
		bus(1'h1, CTRL_ADDR, 32'h202);
		repeat (10) @(posedge clk_i);
		chk("manual mode", 32'h1, {31'h0, dsd_mode_o});
		bus(1'h0, STATUS_ADDR, 32'h0);
		chk("result with auto off", 32'h0, {31'h0, q[0]});
		bus(1'h1, CTRL_ADDR, 32'h203);
		wait_mode(1'h0, 3000);
	endtask : t_manual
	// powers on and soft reset released: zero code alone must not switch
	task automatic t_no_start;
		bus(1'h1, CTRL_ADDR, 32'h239);
		src_kind <= 2'h1;
		repeat (3000) @(posedge clk_i);
		chk("mode kept", 32'h0, {31'h0, dsd_mode_o});
		bus(1'h0, STATUS_ADDR, 32'h0);
		chk("detect idle", 32'h0, {31'h0, q[2]});
	endtask : t_no_start
	// both powers off starts detection; zero code selects one-bit mode
	task automatic t_to_dsd;
		bus(1'h1, CTRL_ADDR, 32'h221);
		wait_mode(1'h1, 3000);
		irst_len(512);
		chk("dsd latency", {23'h0, REG_DLY_LONG}, {23'h0, lat_o});
		bus(1'h0, STATUS_ADDR, 32'h0);
		chk("result dsd", 32'h3, {30'h0, q[1:0]});
	endtask : t_to_dsd
	// stopped bit clock and a toggle that fits no criterion both hold the mode
	task automatic t_hold;
		src_run <= 1'h0;
		repeat (2000) @(posedge clk_i);
		chk("held without bit clock", 32'h1, {31'h0, dsd_mode_o});
		src_run <= 1'h1;
		src_kind <= 2'h2;
		repeat (3000) @(posedge clk_i);
		chk("held on no match", 32'h1, {31'h0, dsd_mode_o});
	endtask : t_hold
	// frame clock with a 32-bit period returns to PCM
	task automatic t_to_pcm;
		src_kind <= 2'h0;
		wait_mode(1'h0, 3000);
		irst_len(256);
		chk("pcm latency", {23'h0, PCM_LAT_FS}, {23'h0, lat_o});
		bus(1'h0, STATUS_ADDR, 32'h0);
		chk("result pcm", 32'h0, {31'h0, q[0]});
	endtask : t_to_pcm
	// no master clock: standby, yet detection goes on
	task automatic t_no_mclk;
		mclk_on <= 1'h0;
		repeat (10) @(posedge clk_i);
		chk("hi-z", 32'h1, {31'h0, hiz_o});
		chk("standby", 32'h1, {31'h0, stby_o});
		src_kind <= 2'h1;
		wait_mode(1'h1, 3000);
		mclk_on <= 1'h1;
		repeat (10) @(posedge clk_i);
		chk("hi-z released", 32'h0, {31'h0, hiz_o});
	endtask : t_no_mclk
	// stuck-high one-bit lines in DSD: mute engages while the mode stays one-bit
	task automatic t_fullscale;
		int n;
		n = 0;
		bus(1'h1, CTRL_ADDR, 32'h339);
		src_kind <= 2'h3;
		while (fs_mute_o !== 1'h1 && n < 3000) begin
			@(posedge clk_i);
			n++;
		end
		chk("full-scale mute", 32'h1, {31'h0, fs_mute_o});
		chk("dsd kept on full scale", 32'h1, {31'h0, dsd_mode_o});
	endtask : t_fullscale
	// power-down pin forces the mode register back to PCM
	task automatic t_pdn;
		pdn_n <= 1'h0;
		repeat (20) @(posedge clk_i);
		chk("pcm in power-down", 32'h0, {31'h0, dsd_mode_o});
		pdn_n <= 1'h1;
		repeat (20) @(posedge clk_i);
	endtask : t_pdn
	// main sequence
	initial begin
		num_errors = 0;
		checks = 0;
		rst_i = 1'h1;
		wb_cyc_i = 1'h0;
		wb_stb_i = 1'h0;
		wb_we_i = 1'h0;
		wb_adr_i = 8'h00;
		wb_sel_i = 4'h0;
		wb_dat_i = 32'h0;
		pdn_n = 1'h0;
		mclk_on = 1'h1;
		src_run = 1'h1;
		src_kind = 2'h0;
		repeat (20) @(posedge clk_i);
		rst_i <= 1'h0;
		pdn_n <= 1'h1;
		t_regs();
		t_manual();
		t_no_start();
		t_to_dsd();
		t_hold();
		t_to_pcm();
		t_no_mclk();
		t_fullscale();
		t_pdn();
		stop_test();
	end
	// watchdog: the sequence needs about 15k cycles
	initial begin
		repeat (60000) @(posedge clk_i);
		chk("watchdog", 32'h0, 32'h1);
		stop_test();
	end
endmodule : tb
